// ---- hdl/output_pin_remap.sv ----
// Output pin remap selector with AHB-Lite register slave
`timescale 1ns/1ps
// Summary of operation
// RULE1 - A selector value n routes peripheral output n to its remappable pin.
// RULE2 - Pin seven selector lives in bits 13..8 of the first map register.
// RULE3 - Pin six selector lives in bits 5..0 of the first map register.
// RULE4 - Pin nine selector lives in bits 13..8 of the second map register.
// RULE5 - Pin eight selector lives in bits 5..0 of the second map register.
// RULE6 - Bits 15..14 and 7..6 read zero and ignore writes.
// RULE7 - Selectors reset to zero; value zero leaves the pin undriven.
module output_pin_remap
    import output_pin_remap_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [63:0] periph_out,
    output logic             remappable_pin_six,
    output logic             remappable_pin_seven,
    output logic             remappable_pin_eight,
    output logic             remappable_pin_nine,
    output logic      [3:0]  pin_driven
);

    // ************************************************************
    // Helpers
    // ************************************************************
    // Pack two selectors into one register image, unimplemented bits zero
    function automatic logic [31:0] pack_pair(input logic [5:0] hi, input logic [5:0] lo);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[HIGH_FIELD_LSB +: SEL_WIDTH] = hi; // RULE6
        v[LOW_FIELD_LSB +: SEL_WIDTH]  = lo; // RULE6
        return v;
    endfunction

    // Read mux by offset; unmapped reads return zero
    function automatic logic [31:0] read_reg(input logic [31:0] a, input remap_state_s s);
        logic [31:0] v;
        v = 32'h0000_0000;
        if ((a & ADDR_DECODE_MASK) == MAP_SIX_SEVEN_OFFSET) begin
            v = pack_pair(s.pin_seven_output_select, s.pin_six_output_select);
        end else if ((a & ADDR_DECODE_MASK) == MAP_EIGHT_NINE_OFFSET) begin
            v = pack_pair(s.pin_nine_output_select, s.pin_eight_output_select);
        end
        return v;
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    remap_state_s state_reg;
    remap_state_s state_next;
    logic         access_taken;
    logic [3:0]   sel_nonzero;
    logic [5:0]   sel_vec [NUM_PINS];

    assign access_taken = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

    // Selectors in pin order six, seven, eight, nine
    assign sel_vec[0] = state_reg.pin_six_output_select;
    assign sel_vec[1] = state_reg.pin_seven_output_select;
    assign sel_vec[2] = state_reg.pin_eight_output_select;
    assign sel_vec[3] = state_reg.pin_nine_output_select;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    // Write data arrives one cycle after its address phase
    always_comb begin
        state_next = state_reg;
        state_next.rd_pending = 1'b0;
        state_next.wr_pending = 1'b0;
        if (state_reg.wr_pending) begin
            if ((state_reg.wr_addr & ADDR_DECODE_MASK) == MAP_SIX_SEVEN_OFFSET) begin
                state_next.pin_seven_output_select = hwdata[HIGH_FIELD_LSB +: SEL_WIDTH]; // RULE2
                state_next.pin_six_output_select   = hwdata[LOW_FIELD_LSB +: SEL_WIDTH];  // RULE3
            end else if ((state_reg.wr_addr & ADDR_DECODE_MASK) == MAP_EIGHT_NINE_OFFSET) begin
                state_next.pin_nine_output_select  = hwdata[HIGH_FIELD_LSB +: SEL_WIDTH]; // RULE4
                state_next.pin_eight_output_select = hwdata[LOW_FIELD_LSB +: SEL_WIDTH];  // RULE5
            end
        end
        if (access_taken) begin
            state_next.wr_pending = hwrite;
            state_next.rd_pending = !hwrite;
            state_next.wr_addr    = haddr;
            // Read data registered at address phase, ready in data phase
            state_next.hrdata     = hwrite ? 32'h0000_0000 : read_reg(haddr, state_next);
        end
        // Pin routing uses the registered selectors, one cycle behind a write
        for (int i = 0; i < NUM_PINS; i++) begin
            state_next.pin_out[i] = (sel_vec[i] != SEL_NONE) && periph_out[sel_vec[i]]; // RULE1 RULE7
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= '0; // RULE7
        end else begin
            state_reg <= state_next;
        end
    end

    // Driven flags from a flop so every output is registered
    logic [3:0] driven_reg;
    generate
        for (genvar g = 0; g < NUM_PINS; g++) begin : g_drv
            assign sel_nonzero[g] = (sel_vec[g] != SEL_NONE); // RULE7
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    driven_reg[g] <= 1'b0;
                end else begin
                    driven_reg[g] <= sel_nonzero[g];
                end
            end
        end
    endgenerate

    // Zero wait states, always OKAY
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata               = state_reg.hrdata;
    assign remappable_pin_six   = state_reg.pin_out[0];
    assign remappable_pin_seven = state_reg.pin_out[1];
    assign remappable_pin_eight = state_reg.pin_out[2];
    assign remappable_pin_nine  = state_reg.pin_out[3];
    assign pin_driven           = driven_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_write_67;
        access_taken && hwrite && ((haddr & ADDR_DECODE_MASK) == MAP_SIX_SEVEN_OFFSET);
    endsequence

    sequence s_write_89;
        access_taken && hwrite && ((haddr & ADDR_DECODE_MASK) == MAP_EIGHT_NINE_OFFSET);
    endsequence

    a_pin_seven_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
        s_write_67 ##1 1'b1 |=> state_reg.pin_seven_output_select == $past(hwdata[13:8]))
        else $error("pin seven selector not written");

    a_pin_six_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
        s_write_67 ##1 1'b1 |=> state_reg.pin_six_output_select == $past(hwdata[5:0]))
        else $error("pin six selector not written");

    a_pin_nine_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
        s_write_89 ##1 1'b1 |=> state_reg.pin_nine_output_select == $past(hwdata[13:8]))
        else $error("pin nine selector not written");

    a_pin_eight_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
        s_write_89 ##1 1'b1 |=> state_reg.pin_eight_output_select == $past(hwdata[5:0]))
        else $error("pin eight selector not written");

    a_unimpl_zero: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
        $past(access_taken && !hwrite) |-> (hrdata[15:14] == 2'h0 && hrdata[7:6] == 2'h0))
        else $error("unimplemented bits read nonzero");

    a_route_six: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
        $past(sel_vec[0] != SEL_NONE) |-> remappable_pin_six == $past(periph_out[sel_vec[0]]))
        else $error("pin six not routed to selected output");

    a_route_nine: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
        $past(sel_vec[3] != SEL_NONE) |-> remappable_pin_nine == $past(periph_out[sel_vec[3]]))
        else $error("pin nine not routed to selected output");

    a_zero_idle: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
        $past(sel_vec[1] == SEL_NONE) |-> !remappable_pin_seven && !pin_driven[1])
        else $error("unassigned pin seven is driven");

    a_read_back: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
        access_taken && !hwrite && ((haddr & ADDR_DECODE_MASK) == MAP_SIX_SEVEN_OFFSET)
        && !state_reg.wr_pending
        |=> hrdata[13:8] == $past(state_reg.pin_seven_output_select))
        else $error("pin seven read back wrong");

    // ************************************************************
    // Routing of the two remaining pins
    // ************************************************************
    // Same one-cycle lag as the routing checks above
    a_route_seven: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
        $past(sel_vec[1] != SEL_NONE) |-> remappable_pin_seven == $past(periph_out[sel_vec[1]]))
        else $error("pin seven not routed to selected output");

    a_route_eight: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
        $past(sel_vec[2] != SEL_NONE) |-> remappable_pin_eight == $past(periph_out[sel_vec[2]]))
        else $error("pin eight not routed to selected output");

    // ************************************************************
    // Unassigned pins stay quiet
    // ************************************************************
    // Peripheral zero may be high; a zero selector must still not drive
    a_zero_six: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
        $past(sel_vec[0] == SEL_NONE) |-> !remappable_pin_six && !pin_driven[0])
        else $error("unassigned pin six is driven");

    a_zero_eight: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
        $past(sel_vec[2] == SEL_NONE) |-> !remappable_pin_eight && !pin_driven[2])
        else $error("unassigned pin eight is driven");

    a_zero_nine: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
        $past(sel_vec[3] == SEL_NONE) |-> !remappable_pin_nine && !pin_driven[3])
        else $error("unassigned pin nine is driven");

    // ************************************************************
    // Driven flags follow nonzero selectors
    // ************************************************************
    // A flag that lags its selector would hide a pin from software
    a_driven_six: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
        $past(sel_vec[0] != SEL_NONE) |-> pin_driven[0])
        else $error("pin six driven flag missing");

    a_driven_seven: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
        $past(sel_vec[1] != SEL_NONE) |-> pin_driven[1])
        else $error("pin seven driven flag missing");

    a_driven_eight: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
        $past(sel_vec[2] != SEL_NONE) |-> pin_driven[2])
        else $error("pin eight driven flag missing");

    a_driven_nine: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
        $past(sel_vec[3] != SEL_NONE) |-> pin_driven[3])
        else $error("pin nine driven flag missing");

    // ************************************************************
    // Read back of the other fields
    // ************************************************************
    // Only checked when no write is landing in the same cycle
    a_read_six: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
        access_taken && !hwrite && ((haddr & ADDR_DECODE_MASK) == MAP_SIX_SEVEN_OFFSET)
        && !state_reg.wr_pending
        |=> hrdata[5:0] == $past(state_reg.pin_six_output_select))
        else $error("pin six read back wrong");

    a_read_nine: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
        access_taken && !hwrite && ((haddr & ADDR_DECODE_MASK) == MAP_EIGHT_NINE_OFFSET)
        && !state_reg.wr_pending
        |=> hrdata[13:8] == $past(state_reg.pin_nine_output_select))
        else $error("pin nine read back wrong");

    a_read_eight: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
        access_taken && !hwrite && ((haddr & ADDR_DECODE_MASK) == MAP_EIGHT_NINE_OFFSET)
        && !state_reg.wr_pending
        |=> hrdata[5:0] == $past(state_reg.pin_eight_output_select))
        else $error("pin eight read back wrong");

    // ************************************************************
    // Unmapped places and upper half
    // ************************************************************
    sequence s_write_other;
        access_taken && hwrite && ((haddr & ADDR_DECODE_MASK) != MAP_SIX_SEVEN_OFFSET)
        && ((haddr & ADDR_DECODE_MASK) != MAP_EIGHT_NINE_OFFSET);
    endsequence

    // A stray write must not disturb any selector
    a_other_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_write_other ##1 1'b1 |=> $stable(sel_vec[0]) && $stable(sel_vec[1])
        && $stable(sel_vec[2]) && $stable(sel_vec[3]))
        else $error("unmapped write changed a selector");

    a_other_read: assert property (@(posedge clk) disable iff (sys_rst)
        access_taken && !hwrite && ((haddr & ADDR_DECODE_MASK) != MAP_SIX_SEVEN_OFFSET)
        && ((haddr & ADDR_DECODE_MASK) != MAP_EIGHT_NINE_OFFSET)
        |=> hrdata == 32'h0000_0000)
        else $error("unmapped read nonzero");

    a_upper_zero: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
        $past(access_taken && !hwrite) |-> hrdata[31:16] == 16'h0000)
        else $error("upper read bits nonzero");

    // ************************************************************
    // Bus response
    // ************************************************************
    // Skips the first edge after reset, where ready is still low
    a_bus_okay: assert property (@(posedge clk) disable iff (sys_rst)
        $past(!sys_rst) |-> hreadyout && !hresp)
        else $error("bus not ready or not okay");

    // Read data stands until the next taken access
    a_rdata_hold: assert property (@(posedge clk) disable iff (sys_rst)
        $past(!access_taken) |-> $stable(hrdata))
        else $error("read data changed without access");

endmodule // output_pin_remap

// ---- hdl/output_pin_remap_pkg.sv ----
// Package with register map and field layout of the output pin remap block
package output_pin_remap_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [31:0] MAP_SIX_SEVEN_OFFSET   = 32'h0000_0000;
    localparam logic [31:0] MAP_EIGHT_NINE_OFFSET  = 32'h0000_0004;
    localparam logic [31:0] ADDR_DECODE_MASK       = 32'h0000_00ff;

    // ************************************************************
    // Field layout
    // ************************************************************
    localparam int          SEL_WIDTH              = 6;
    localparam int          HIGH_FIELD_LSB         = 8;
    localparam int          LOW_FIELD_LSB          = 0;
    localparam int          NUM_PINS               = 4;
    localparam int          NUM_PERIPH             = 64;
    localparam logic [5:0]  SEL_RESET              = 6'h00;
    localparam logic [5:0]  SEL_NONE               = 6'h00;

    // ************************************************************
    // AHB-Lite encodings
    // ************************************************************
    localparam logic [1:0]  HTRANS_NONSEQ          = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ             = 2'h3;

    // ************************************************************
    // Register state
    // ************************************************************
    typedef struct packed {
        logic [5:0]  pin_six_output_select;
        logic [5:0]  pin_seven_output_select;
        logic [5:0]  pin_eight_output_select;
        logic [5:0]  pin_nine_output_select;
        logic        wr_pending;
        logic        rd_pending;
        logic [31:0] wr_addr;
        logic [31:0] hrdata;
        logic [3:0]  pin_out;
    } remap_state_s;

endpackage

// ---- tb/periph_bank.sv ----
// Behavioural bank of peripheral outputs that feeds the remap block
`timescale 1ns/1ps
module periph_bank (
    input  wire logic [5:0]  hot_idx,
    input  wire logic        invert,
    output logic      [63:0] periph_out
);
    // One line differs from the rest, so a wrong selector shows at the pin
    // Inversion also catches paths that are stuck low as well as stuck high
    assign periph_out = (64'h1 << hot_idx) ^ {64{invert}};
endmodule // periph_bank

// ---- tb/tb_top.sv ----
// Self-checking testbench for the output pin remap block
`timescale 1ns/1ps
module tb_top
    import output_pin_remap_pkg::*;
;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        hsel, hwrite, hresp, hreadyout, invert;
    logic        six, seven, eight, nine;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  pin_driven;
    logic [5:0]  hot_idx;
    logic [63:0] periph_out;
    int          miscompares, n_checks, v;

    // ****************************************
    // Clock, design and peripheral bank
    // ****************************************
    always #50 clk = ~clk;
    output_pin_remap dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .periph_out(periph_out), .remappable_pin_six(six), .remappable_pin_seven(seven),
        .remappable_pin_eight(eight), .remappable_pin_nine(nine), .pin_driven(pin_driven));
    periph_bank bank (.hot_idx(hot_idx), .invert(invert), .periph_out(periph_out));

    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic close_out;
        if (miscompares == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Sampled at the falling edge, so the next rising edge sees the same level
    task automatic wait_rdy;
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 20);
        if (hreadyout !== 1'b1) begin
            miscompares++;
            $display("Error at %0t: bus never ready", $time);
            close_out();
        end
    endtask

    // Entered just after a rising edge, leaves at the edge ending the data phase
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
        haddr <= addr;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        wait_rdy();
        @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wdata;
        wait_rdy();
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
        @(posedge clk);
    endtask

    // Pins follow one edge after the selector lands
    task automatic pins(input logic [3:0] exp_pin, input logic [3:0] exp_drv);
        @(negedge clk);
        @(negedge clk);
        chk({28'h0, nine, eight, seven, six}, {28'h0, exp_pin});
        chk({28'h0, pin_driven}, {28'h0, exp_drv});
        @(posedge clk);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        hsel = 1'b1;
        hsize = 3'h2;
        haddr = 32'h0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hwdata = 32'h0;
        hot_idx = 6'h15;
        invert = 1'b0;
        miscompares = 0;
        n_checks = 0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        xfer(1'b0, MAP_SIX_SEVEN_OFFSET, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, MAP_EIGHT_NINE_OFFSET, 32'h0);
        chk(rd, 32'h0);
        // Unimplemented bits set on write must read back clear
        xfer(1'b1, MAP_SIX_SEVEN_OFFSET, 32'hffff_ffff);
        xfer(1'b0, MAP_SIX_SEVEN_OFFSET, 32'h0);
        chk(rd, 32'h0000_3f3f);
        xfer(1'b1, MAP_EIGHT_NINE_OFFSET, 32'hffff_ea95);
        xfer(1'b0, MAP_EIGHT_NINE_OFFSET, 32'h0);
        chk(rd, 32'h0000_2a15);
        pins(4'b0100, 4'hf);
        // Unmapped place: ignored write, zero read, second map register untouched
        xfer(1'b1, 32'h0000_0008, 32'hffff_ffff);
        xfer(1'b0, 32'h0000_0008, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, MAP_EIGHT_NINE_OFFSET, 32'h0);
        chk(rd, 32'h0000_2a15);
        // Walk selector values over all four pins, one pin differing from the rest at a time
        for (v = 1; v <= 60; v++) begin
            hot_idx <= 6'(v + v % 4);
            invert <= v[2];
            xfer(1'b1, MAP_SIX_SEVEN_OFFSET, {18'h0, 6'(v + 1), 2'b0, 6'(v)});
            xfer(1'b1, MAP_EIGHT_NINE_OFFSET, {18'h0, 6'(v + 3), 2'b0, 6'(v + 2)});
            pins(4'(1 << (v % 4)) ^ {4{v[2]}}, 4'hf);
        end
        // Zero selector keeps the pin low although peripheral zero is high
        invert <= 1'b1;
        hot_idx <= 6'h05;
        xfer(1'b1, MAP_SIX_SEVEN_OFFSET, 32'h0);
        xfer(1'b1, MAP_EIGHT_NINE_OFFSET, 32'h0000_0100);
        pins(4'b1000, 4'b1000);
        // Reset in mid-run clears every selector
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        xfer(1'b0, MAP_EIGHT_NINE_OFFSET, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, MAP_SIX_SEVEN_OFFSET, 32'h0);
        chk(rd, 32'h0);
        pins(4'h0, 4'h0);
        close_out();
    end
endmodule // tb_top
